// ### verilog/tdc_stop_delay_timeout_cfg.sv
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
//Contract
// - Enabled interrupt sources are ORed onto one interrupt output.
// - Bit 31 lets a measurement timeout raise the interrupt.
// - Bit 30 lets completion of all expected hits raise the interrupt.
// - Bit 29 lets arithmetic unit completion raise the interrupt.
// - Register 6 bit 21 enables the memory operation done source.
// - Channel 2 edge bit set counts both edges, else one edge.
// - Channel 1 edge bit set counts both edges, else one edge.
// - First delay sets wait before hit 1 on channel 1 is accepted.
// - Delays are unsigned 14.5 fixed point in reference periods.
// - First delay spans zero to its full representable value.
// - Second delay gates hit 2 of channel 1 likewise.
// - Third delay gates hit 3 of channel 1 likewise.
// - With error fill set, a timeout forces the result to all ones, unless unit completion comes in that same cycle.
// - Mode 2 timeout predivider codes select 64, 256, 1024, 4096 us.
// - Low eight bits of each register are stored with no effect.
// - Analog enable powers analog only during measurement, muxing stops.
module tdc_stop_delay_timeout_cfg
  import tdc_cfg_pkg::*;
(
  input  wire logic        i_mclk,        // System clock, 25 MHz.
  input  wire logic        i_arst_n,      // Asynchronous reset, active low.
  input  wire logic [3:0]  i_addr,        // Register index.
  input  wire logic [31:0] i_wdata,       // Write data.
  input  wire logic        i_wr,          // Write strobe.
  input  wire logic        i_rd,          // Read strobe.
  output logic      [31:0] o_rdata,       // Read data, one cycle after strobe.
  input  wire logic        i_ref_tick,    // Reference period pulse.
  input  wire logic        i_hs_tick,     // High speed clock period pulse.
  input  wire logic        i_meas_start,  // Measurement start pulse.
  input  wire logic        i_mode2,       // Measurement mode 2 selected.
  input  wire logic        i_stop1,       // Stop channel 1 pin.
  input  wire logic        i_stop2,       // Stop channel 2 pin.
  input  wire logic [2:0]  i_hits_expect, // Hits expected on channel 1.
  input  wire logic        i_alu_done,    // Arithmetic unit finished pulse.
  input  wire logic        i_nvm_done,    // Memory operation finished pulse.
  input  wire logic [31:0] i_alu_result,  // Arithmetic unit result.
  output logic      [31:0] o_result,      // Output result register.
  output logic             o_stop1_hit,   // Accepted channel 1 hit pulse.
  output logic             o_stop2_hit,   // Channel 2 hit pulse.
  output logic             o_analog_pwr,  // Analog section powered.
  output logic             o_analog_sel,  // Stops routed through analog mux.
  output logic             o_irq_n        // Interrupt, active low.
);

  typedef struct packed {
    logic [31:0]          reg2;
    logic [31:0]          reg3;
    logic [31:0]          reg4;
    logic [31:0]          reg6;
    logic [31:0]          rdata;
    logic [31:0]          result;
    logic [TMO_CNT_W-1:0] tmo_cnt;
    logic                 measuring;
    logic                 timed_out;
    logic [2:0]           hit_cnt;
    logic                 hits_done;
    logic                 irq;
  } state_type;

  state_type                  s_q;
  state_type                  s_d;
  logic                       hit1_raw;
  logic                       hit2_raw;
  logic [2:0]                 win_en;
  logic                       win_sel;
  logic                       tmo_evt;
  logic                       hits_evt;
  logic [TMO_CNT_W-1:0]       tmo_limit;
  logic [DELAY_W-1:0]         delay_val [3];

  // Delay fields, each 14 integer and 5 fractional bits above the free byte.
  assign delay_val[0] = s_q.reg2[DELAY_LSB +: DELAY_W];
  assign delay_val[1] = s_q.reg3[DELAY_LSB +: DELAY_W];
  assign delay_val[2] = s_q.reg4[DELAY_LSB +: DELAY_W];

  // Edge sensitivity per channel; single edge defaults to rising.
  tdc_edge_detect u_edge1 (
    .i_mclk       (i_mclk),
    .i_arst_n     (i_arst_n),
    .i_pin        (i_stop1),
    .i_both_edges (s_q.reg2[CH1_BOTH_BIT]),
    .i_falling    (1'b0),
    .o_hit        (hit1_raw)
  );

  tdc_edge_detect u_edge2 (
    .i_mclk       (i_mclk),
    .i_arst_n     (i_arst_n),
    .i_pin        (i_stop2),
    .i_both_edges (s_q.reg2[CH2_BOTH_BIT]),
    .i_falling    (1'b0),
    .o_hit        (hit2_raw)
  );

  // One stop-enable delay unit per gated hit of channel 1.
  for (genvar g = 0; g < 3; g++) begin : g_dly
    tdc_stop_delay u_dly (
      .i_mclk     (i_mclk),
      .i_arst_n   (i_arst_n),
      .i_start    (i_meas_start),
      .i_ref_tick (i_ref_tick),
      .i_delay    (delay_val[g]),
      .o_enable   (win_en[g])
    );
  end

  // Hits beyond the third are not gated by a delay.
  always_comb begin
    case (s_q.hit_cnt)
      3'h0:    win_sel = win_en[0];
      3'h1:    win_sel = win_en[1];
      3'h2:    win_sel = win_en[2];
      default: win_sel = 1'b1;
    endcase
  end

  assign o_stop1_hit = hit1_raw & s_q.measuring & win_sel;
  assign o_stop2_hit = hit2_raw & s_q.measuring;
  assign tmo_limit   = prediv_ticks(s_q.reg3[PREDIV_LSB +: 2]);
  assign tmo_evt     = s_q.measuring && i_mode2 && i_hs_tick && (s_q.tmo_cnt + 1'b1 >= tmo_limit);
  assign hits_evt    = o_stop1_hit && (i_hits_expect != 3'h0) && (s_q.hit_cnt + 3'h1 == i_hits_expect);

  // Register writes, measurement tracking, result and interrupt.
  always_comb begin
    s_d = s_q;
    if (i_wr) begin
      // All 32 bits are stored; the free low byte drives nothing.
      if (i_addr == ADDR_INT_DLY1) begin
        s_d.reg2 = i_wdata;
      end else if (i_addr == ADDR_TMO_DLY2) begin
        s_d.reg3 = i_wdata;
      end else if (i_addr == ADDR_DLY3) begin
        s_d.reg4 = i_wdata;
      end else if (i_addr == ADDR_ANALOG_CFG) begin
        s_d.reg6 = i_wdata;
      end
    end
    s_d.rdata = '0;
    if (i_rd) begin
      if (i_addr == ADDR_INT_DLY1) begin
        s_d.rdata = s_q.reg2;
      end else if (i_addr == ADDR_TMO_DLY2) begin
        s_d.rdata = s_q.reg3;
      end else if (i_addr == ADDR_DLY3) begin
        s_d.rdata = s_q.reg4;
      end else if (i_addr == ADDR_ANALOG_CFG) begin
        s_d.rdata = s_q.reg6;
      end else if (i_addr == ADDR_STATUS) begin
        s_d.rdata = {28'h0, s_q.hits_done, s_q.timed_out, s_q.measuring, s_q.irq};
      end
    end
    // A new start restarts the timeout and hit count.
    if (i_meas_start) begin
      s_d.measuring = 1'b1;
      s_d.timed_out = 1'b0;
      s_d.hits_done = 1'b0;
      s_d.tmo_cnt   = '0;
      s_d.hit_cnt   = '0;
    end else if (s_q.measuring) begin
      if (i_mode2 && i_hs_tick) begin
        s_d.tmo_cnt = s_q.tmo_cnt + 1'b1;
      end
      if (o_stop1_hit && s_q.hit_cnt != 3'h7) begin
        s_d.hit_cnt = s_q.hit_cnt + 3'h1;
      end
      if (tmo_evt) begin
        s_d.timed_out = 1'b1;
        s_d.measuring = 1'b0;
      end else if (hits_evt) begin
        s_d.hits_done = 1'b1;
        s_d.measuring = 1'b0;
      end
    end
    // Timeout overrides the computed value when error fill is on, but a unit result in the timeout cycle itself is kept.
    if (i_alu_done) begin
      s_d.result = (s_q.timed_out && s_q.reg3[ERR_FILL_BIT]) ? ERROR_FILL : i_alu_result;
    end else if (tmo_evt && s_q.reg3[ERR_FILL_BIT]) begin
      s_d.result = ERROR_FILL;
    end
    // Interrupt follows the latest event; a new start releases it, but an event
    // in the same cycle still wins.
    if (i_meas_start) begin
      s_d.irq = 1'b0;
    end
    if ((tmo_evt && s_q.reg2[INT_TIMEOUT_BIT])
        || (hits_evt && s_q.reg2[INT_HITS_BIT])
        || (i_alu_done && s_q.reg2[INT_ALU_BIT])
        || (i_nvm_done && s_q.reg6[NVM_INT_BIT])) begin
      s_d.irq = 1'b1;
    end
  end

  // Analog section is powered only while a measurement runs.
  assign o_analog_pwr = s_q.reg6[ANALOG_EN_BIT] & s_q.measuring;
  assign o_analog_sel = s_q.reg6[ANALOG_EN_BIT];
  assign o_rdata      = s_q.rdata;
  assign o_result     = s_q.result;
  assign o_irq_n      = ~s_q.irq;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q      <= '0;
      s_q.reg2 <= RST_REG2;
      s_q.reg3 <= RST_REG3;
      s_q.reg4 <= RST_REG4;
      s_q.reg6 <= RST_REG6;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // tdc_stop_delay_timeout_cfg
`default_nettype wire

// ### verilog/tdc_cfg_pkg.sv
package tdc_cfg_pkg;

  // Register indices on the plain register port.
  localparam logic [3:0] ADDR_INT_DLY1   = 4'h2;
  localparam logic [3:0] ADDR_TMO_DLY2   = 4'h3;
  localparam logic [3:0] ADDR_DLY3       = 4'h4;
  localparam logic [3:0] ADDR_ANALOG_CFG = 4'h6;
  localparam logic [3:0] ADDR_STATUS     = 4'h8;

  // Field positions.
  localparam int INT_TIMEOUT_BIT   = 31;
  localparam int INT_HITS_BIT      = 30;
  localparam int INT_ALU_BIT       = 29;
  localparam int CH2_BOTH_BIT      = 28;
  localparam int CH1_BOTH_BIT      = 27;
  localparam int ERR_FILL_BIT      = 31;
  localparam int PREDIV_LSB        = 29;
  localparam int DELAY_LSB         = 8;
  localparam int DELAY_W           = 19;
  localparam int DELAY_FRAC_W      = 5;
  localparam int FREE_W            = 8;
  localparam int NVM_INT_BIT       = 21;
  localparam int ANALOG_EN_BIT     = 31;

  // Reset values, all zero.
  localparam logic [31:0] RST_REG2 = 32'h0000_0000;
  localparam logic [31:0] RST_REG3 = 32'h0000_0000;
  localparam logic [31:0] RST_REG4 = 32'h0000_0000;
  localparam logic [31:0] RST_REG6 = 32'h0000_0000;

  // Error fill value written to the result on timeout.
  localparam logic [31:0] ERROR_FILL = 32'hFFFF_FFFF;

  // Timeout predivider: times in microseconds on a 4 MHz high speed clock.
  localparam int HS_CLK_MHZ  = 4;
  localparam int TMO0_US     = 64;
  localparam int TMO1_US     = 256;
  localparam int TMO2_US     = 1024;
  localparam int TMO3_US     = 4096;
  localparam int TMO_CNT_W   = 15;

  // Timeout predivider code select.
  typedef enum logic [1:0] {
    PREDIV_64,
    PREDIV_256,
    PREDIV_1024,
    PREDIV_4096
  } prediv_type;

  // Converts a predivider code to a count of high speed clock ticks.
  function automatic logic [TMO_CNT_W-1:0] prediv_ticks(input logic [1:0] code);
    int us;
    case (code)
      2'h0:    us = TMO0_US;
      2'h1:    us = TMO1_US;
      2'h2:    us = TMO2_US;
      default: us = TMO3_US;
    endcase
    prediv_ticks = TMO_CNT_W'(us * HS_CLK_MHZ);
  endfunction

endpackage

// ### verilog/tdc_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
// Synchronises a stop input and flags the selected edges as hits.
module tdc_edge_detect
  import tdc_cfg_pkg::*;
(
  input  wire logic i_mclk,       // System clock.
  input  wire logic i_arst_n,     // Asynchronous reset, active low.
  input  wire logic i_pin,        // Stop input from the pin.
  input  wire logic i_both_edges, // One counts both edges.
  input  wire logic i_falling,    // Single edge choice: one selects falling.
  output logic      o_hit         // One-cycle hit pulse.
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic last;
  } state_type;

  state_type s_q;
  state_type s_d;
  logic      rise;
  logic      fall;

  // Edges are judged only on the second stage to keep metastability out.
  always_comb begin
    s_d       = s_q;
    s_d.sync1 = i_pin;
    s_d.sync2 = s_q.sync1;
    s_d.last  = s_q.sync2;
  end

  assign rise  = s_q.sync2 & ~s_q.last;
  assign fall  = ~s_q.sync2 & s_q.last;
  assign o_hit = i_both_edges ? (rise | fall) : (i_falling ? fall : rise);

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // tdc_edge_detect
`default_nettype wire

// ### verilog/tdc_stop_delay.sv
`timescale 1ns/1ps
`default_nettype none
// Counts reference periods in fixed point and opens a stop window on expiry.
module tdc_stop_delay
  import tdc_cfg_pkg::*;
(
  input  wire logic               i_mclk,    // System clock.
  input  wire logic               i_arst_n,  // Asynchronous reset, active low.
  input  wire logic               i_start,   // One-cycle measurement start.
  input  wire logic               i_ref_tick,// One reference period per pulse.
  input  wire logic [DELAY_W-1:0] i_delay,   // Delay, 14.5 fixed point.
  output logic                    o_enable   // Stop acceptance enabled.
);

  typedef struct packed {
    logic [DELAY_W-1:0] count;
    logic               busy;
    logic               open;
  } state_type;

  state_type s_q;
  state_type s_d;

  // Each reference tick adds one whole period, i.e. 32 fractional steps, so
  // fractional delays round up to the next whole reference period.
  always_comb begin
    s_d = s_q;
    if (i_start) begin
      s_d.count = '0;
      s_d.busy  = (i_delay != '0);
      s_d.open  = (i_delay == '0);
    end else if (s_q.busy && i_ref_tick) begin
      s_d.count = s_q.count + DELAY_W'(1 << DELAY_FRAC_W);
      if ({1'b0, s_q.count} + (20'(1) << DELAY_FRAC_W) >= {1'b0, i_delay}) begin
        s_d.busy = 1'b0;
        s_d.open = 1'b1;
      end
    end
  end

  assign o_enable = s_q.open;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // tdc_stop_delay
`default_nettype wire

// ### testbench/tdc_cfg_props.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the register port, interrupt and channel 2 hit output of the block.
module tdc_cfg_props
  import tdc_cfg_pkg::*;
(
  input wire logic        i_mclk,       // Clock.
  input wire logic        i_arst_n,     // Reset.
  input wire logic [3:0]  i_addr,       // Index.
  input wire logic [31:0] i_wdata,      // Data.
  input wire logic        i_wr,         // Write.
  input wire logic        i_rd,         // Read.
  input wire logic [31:0] o_rdata,      // Read data.
  input wire logic        i_alu_done,   // Unit done.
  input wire logic        i_nvm_done,   // Memory done.
  input wire logic [31:0] o_result,     // Result.
  input wire logic        o_stop2_hit,  // Hit two.
  input wire logic        o_analog_pwr, // Power.
  input wire logic        o_analog_sel, // Mux.
  input wire logic        o_irq_n       // Interrupt.
);
  logic [31:0] sh_q [2:6];

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  // Shadow of what software wrote, so reads can be judged without peeking inside.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) sh_q <= '{default: '0};
    else if (i_wr && (i_addr inside {[2:4], 6})) sh_q[i_addr] <= i_wdata;
  end

  rd_idle_zero_a: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data not zero outside a read");
  rd_mapped_a: assert property ($past(i_rd) && ($past(i_addr) inside {[2:4], 6})
    |-> o_rdata == sh_q[$past(i_addr)]) else $error("read data differs from written");
  rd_unmapped_a: assert property ($past(i_rd) && !($past(i_addr) inside {[2:4], 6, 8})
    |-> o_rdata == '0) else $error("unmapped read not zero");
  alu_irq_a: assert property (i_alu_done && sh_q[2][INT_ALU_BIT] |-> ##[1:2] !o_irq_n)
    else $error("unit done did not raise interrupt");
  nvm_irq_a: assert property (i_nvm_done && sh_q[6][NVM_INT_BIT] |-> ##[1:2] !o_irq_n)
    else $error("memory done did not raise interrupt");
  analog_sel_a: assert property (o_analog_sel == sh_q[6][ANALOG_EN_BIT])
    else $error("analog mux differs from enable");
  analog_pwr_a: assert property (!sh_q[6][ANALOG_EN_BIT] |-> !o_analog_pwr)
    else $error("analog powered while disabled");
  err_fill_a: assert property ($changed(o_result) && o_result == ERROR_FILL |-> sh_q[3][ERR_FILL_BIT])
    else $error("error fill without enable");
  stop2_pulse_a: assert property (o_stop2_hit |=> !o_stop2_hit)
    else $error("hit pulse longer than one cycle");

  alu_irq_c: cover property (i_alu_done && sh_q[2][INT_ALU_BIT]);
  fill_c: cover property (o_result == ERROR_FILL);
  hit2_c: cover property (o_stop2_hit && sh_q[2][CH2_BOTH_BIT]);
endmodule // tdc_cfg_props
`default_nettype wire

// ### testbench/tdc_stop_delay_timeout_cfg_bench.sv
`timescale 1ns/1ps
`default_nettype none
module tdc_stop_delay_timeout_cfg_bench;
  import tdc_cfg_pkg::*;
  logic        i_mclk = 0, i_arst_n = 0, i_wr = 0, i_rd = 0, i_ref_tick = 0, i_hs_tick = 0;
  logic        i_meas_start = 0, i_mode2 = 0, i_stop1 = 0, i_stop2 = 0;
  logic        i_alu_done = 0, i_nvm_done = 0;
  logic [3:0]  i_addr = '0;
  logic [2:0]  i_hits_expect = '0;
  logic [31:0] i_wdata = '0, i_alu_result = 32'h1234_5678, o_rdata, o_result;
  logic        o_stop1_hit, o_stop2_hit, o_analog_pwr, o_analog_sel, o_irq_n;
  int          err_count = 0, tests_run = 0, cyc = 0, n1 = 0, n2 = 0, b1, b2;

  tdc_stop_delay_timeout_cfg uut (.*);

  // Clock at 25 MHz.
  initial forever #20 i_mclk = ~i_mclk;

  // Hit counters and the hang limit; the whole run needs about 22000 cycles.
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (o_stop1_hit === 1'b1) n1 <= n1 + 1;
    if (o_stop2_hit === 1'b1) n2 <= n2 + 1;
    if (cyc == 40000) begin
      err_count++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  // One bus cycle; strobes stay up between calls so ops run back to back.
  task automatic op(input logic w, input logic [3:0] a, input logic [31:0] d, input string nm = "");
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= d;
    step(1);
    if (!w) chk(nm, o_rdata, d);
  endtask

  task automatic idle;
    i_wr <= 0;
    i_rd <= 0;
    step(1);
  endtask

  task automatic start;
    i_meas_start <= 1;
    step(1);
    i_meas_start <= 0;
    step(1);
  endtask

  task automatic close_out;
    $display("tests_run %0d err_count %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence.
  initial begin
    step(6);
    i_arst_n <= 1;
    step(1);
    for (int a = 2; a < 16; a++) if (a != 8) op(0, 4'(a), '0, "reset value");
    idle;
    $display("test reset done");
    // Nonzero delays are only legal while the analog section is enabled.
    op(1, ADDR_ANALOG_CFG, 32'h8000_0000);
    op(1, ADDR_INT_DLY1, 32'hFFFF_FFA5);
    op(1, ADDR_TMO_DLY2, 32'hE7FF_FF5A);
    op(1, ADDR_DLY3, 32'h07FF_FF3C);
    op(1, 4'h5, 32'hFFFF_FFFF);
    op(0, ADDR_INT_DLY1, 32'hFFFF_FFA5, "reg2");
    op(0, ADDR_TMO_DLY2, 32'hE7FF_FF5A, "reg3");
    op(0, ADDR_DLY3, 32'h07FF_FF3C, "reg4");
    op(0, 4'h5, '0, "unmapped");
    // Every delay goes back to zero before the analog section is switched off.
    op(1, ADDR_TMO_DLY2, '0);
    op(1, ADDR_DLY3, '0);
    op(1, ADDR_INT_DLY1, 32'h2000_0000);
    op(1, ADDR_ANALOG_CFG, 32'h0020_0000);
    idle;
    $display("test registers done");
    i_alu_done <= 1;
    step(1);
    i_alu_done <= 0;
    step(2);
    chk("irq unit", o_irq_n, 0);
    chk("alu result", o_result, 32'h1234_5678);
    start;
    chk("irq cleared", o_irq_n, 1);
    i_nvm_done <= 1;
    step(1);
    i_nvm_done <= 0;
    step(2);
    chk("irq memory", o_irq_n, 0);
    op(1, ADDR_ANALOG_CFG, '0);
    op(1, ADDR_INT_DLY1, 32'h8000_0000);
    idle;
    start;
    i_nvm_done <= 1;
    step(1);
    i_nvm_done <= 0;
    step(2);
    chk("irq masked", o_irq_n, 1);
    $display("test interrupts done");
    i_mode2 <= 1;
    i_hs_tick <= 1;
    for (int c = 0; c < 4; c++) begin
      // The last pass leaves the longest code in place, as a host at 4 MHz should.
      op(1, ADDR_TMO_DLY2, {c == 0, 2'(c), 29'h0});
      idle;
      start;
      step((64 << (2 * c)) * HS_CLK_MHZ - 8);
      chk("timeout early", o_irq_n, 1);
      step(12);
      chk("timeout irq", o_irq_n, 0);
      if (c == 0) chk("error fill", o_result, ERROR_FILL);
    end
    i_mode2 <= 0;
    i_hs_tick <= 0;
    op(0, ADDR_STATUS, 32'h0000_0005, "status timeout");
    $display("test timeout done");
    // Nonzero delay needs the analog section on.
    op(1, ADDR_ANALOG_CFG, 32'h8000_0000);
    op(1, ADDR_INT_DLY1, {3'b010, 2'b00, 19'(10 << DELAY_FRAC_W), 8'h00});
    idle;
    i_ref_tick <= 1;
    i_hits_expect <= 3'h2;
    start;
    chk("analog power", o_analog_pwr, 1);
    b1 = n1;
    i_stop1 <= 1;
    step(4);
    i_stop1 <= 0;
    step(4);
    chk("hit before delay", 32'(n1 - b1), 0);
    step(6);
    for (int k = 0; k < 2; k++) begin
      i_stop1 <= 1;
      step(4);
      i_stop1 <= 0;
      step(4);
    end
    chk("hits after delay", 32'(n1 - b1), 2);
    chk("irq hits", o_irq_n, 0);
    op(0, ADDR_STATUS, 32'h0000_0009, "status hits");
    $display("test delay done");
    for (int e = 0; e < 2; e++) begin
      op(1, ADDR_INT_DLY1, {3'b000, e[0], e[0], 27'h0});
      idle;
      start;
      b1 = n1;
      b2 = n2;
      i_stop1 <= 1;
      i_stop2 <= 1;
      step(5);
      i_stop1 <= 0;
      i_stop2 <= 0;
      step(5);
      chk("ch1 hits", 32'(n1 - b1), 32'(1 + e));
      chk("ch2 hits", 32'(n2 - b2), 32'(1 + e));
    end
    op(1, ADDR_ANALOG_CFG, '0);
    idle;
    $display("test edges done");
    close_out();
  end
endmodule // tdc_stop_delay_timeout_cfg_bench

bind tdc_stop_delay_timeout_cfg tdc_cfg_props props_i (.*);
`default_nettype wire
